/* eeprom_shifter_pkg.sv */
// constants and types shared by the three-wire eeprom shifter
package eeprom_shifter_pkg;
    // serial clock derived from the system clock
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned SCK_KHZ      = 500;
    localparam int unsigned SCK_HALF_CYC = CLK_HZ / (2 * SCK_KHZ * 1000);
    localparam logic [3:0]  HALF_LAST    = 4'(SCK_HALF_CYC - 1);

    // interface selection value that enables three-wire mode
    localparam logic [1:0] PORT_SEL_3WIRE = 2'h3;

    // control register field positions
    localparam int unsigned CTL_WFR_BIT  = 7;
    localparam int unsigned CTL_BUSY_BIT = 6;
    localparam int unsigned CTL_HIZ_BIT  = 5;
    localparam int unsigned CTL_RD_BIT   = 4;
    localparam int unsigned CTL_CNT_MSB  = 3;
    localparam int unsigned CTL_CNT_LSB  = 0;
    localparam logic [3:0]  MAX_BITS     = 4'h8;

    // values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic       CS_RESET   = 1'b0;

    // command queue: control byte over data byte
    localparam int unsigned CMD_W      = 16;
    localparam int unsigned CMD_DEPTH  = 8;
    localparam int unsigned CMD_CTL_LO = 8;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOW  = 4'b0010,
        ST_HIGH = 4'b0100,
        ST_WAIT = 4'b1000
    } shift_state_type;
endpackage

/* cmd_fifo.sv */
// small synchronous fifo with valid/ready on both sides
module cmd_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;
    logic             push;
    logic             pop;

    // extra pointer bit tells full from empty
    assign out_valid_o = wr_ptr_ff != rd_ptr_ff;
    assign in_ready_o  = (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]) || (wr_ptr_ff[AW] == rd_ptr_ff[AW]);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_ff[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule

/* three_wire_eeprom_shifter.sv */
// three-wire serial eeprom shifter with queued control writes
// Functional notes
// - drive a 500 kHz serial clock, share one data line, chip select on an io pin.
// - three-wire mode runs only while interface selection equals 3.
// - each control write accepted by the queue starts one transfer of up to 8 bits.
// - wait-for-ready holds busy after transfer until a rising edge on data.
// - wait-for-ready is ignored when float-after-transfer is clear.
// - control bit 6 reads busy; its fall raises the done interrupt.
// - float bit releases the data driver on the same cycle as the last rising clock.
// - control bit 4 selects read into the data register, else write.
// - bits 3..0 give the clock count, zero through eight.
// - read samples msb first, right-justified into the data register.
// - write sends msb first out of the data register top bit.
// - count zero gives no clocks, only drives or floats the data line.
// - control and data registers are special-function registers of the processor.
module three_wire_eeprom_shifter
    import eeprom_shifter_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    // special-function register access
    input  wire logic       sfr_ctrl_wr_i,
    input  wire logic       sfr_data_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] ctrl_rdata_o,
    output logic      [7:0] data_rdata_o,
    output logic            cmd_ready_o,
    // interface selection and chip select pin
    input  wire logic [1:0] eeprom_port_select_i,
    input  wire logic       cs_wr_i,
    input  wire logic       cs_val_i,
    output logic            general_io_pin_o,
    // serial pins
    output logic            sck_o,
    output logic            serial_data_signal_o,
    output logic            serial_data_signal_oe_n_o,
    input  wire logic       serial_data_line_i,
    // completion event
    output logic            eeprom_done_irq_o
);
    shift_state_type  st_ff;
    logic [7:0]       ctrl_ff;
    logic [7:0]       data_ff;
    logic [7:0]       shreg_ff;
    logic [3:0]       half_ff;
    logic [3:0]       bits_left_ff;
    logic [3:0]       xfer_cnt_ff;
    logic [3:0]       edge_cnt_ff;
    logic             rd_ff;
    logic             hiz_ff;
    logic             wfr_ff;
    logic             sck_ff;
    logic             sd_out_ff;
    logic             sd_oe_n_ff;
    logic             cs_ff;
    logic             busy_prev_ff;
    logic             irq_ff;
    logic             sync1_ff;
    logic             sync2_ff;
    logic             sync3_ff;
    logic             lvl_ff;
    logic             mode_on;
    logic             cmd_valid;
    logic             cmd_pop;
    logic [CMD_W-1:0] cmd;
    logic [7:0]       cmd_ctl;
    logic [3:0]       cmd_cnt;
    logic             sd_now;
    logic             rdy_rise;
    logic             busy;
    logic             half_done;
    logic             xfer_end;

    assign mode_on   = eeprom_port_select_i == PORT_SEL_3WIRE;
    assign cmd_ctl   = cmd[CMD_W-1:CMD_CTL_LO];
    // counts above eight are not allowed; clamp rather than overrun the byte
    assign cmd_cnt   = (cmd_ctl[CTL_CNT_MSB:CTL_CNT_LSB] > MAX_BITS) ? MAX_BITS
                                                                     : cmd_ctl[CTL_CNT_MSB:CTL_CNT_LSB];
    assign cmd_pop   = cmd_valid && mode_on && (st_ff == ST_IDLE);
    assign half_done = half_ff == HALF_LAST;
    assign xfer_end  = mode_on && (st_ff == ST_HIGH) && half_done && (bits_left_ff == 4'h0);
    assign busy      = (st_ff != ST_IDLE) || cmd_valid;

    // queued control writes keep their data byte; full queue refuses writes
    cmd_fifo #(
        .WIDTH (CMD_W),
        .DEPTH (CMD_DEPTH)
    ) u_cmd_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  (sfr_ctrl_wr_i && mode_on),
        .in_ready_o  (cmd_ready_o),
        .in_data_i   ({sfr_wdata_i, data_ff}),
        .out_valid_o (cmd_valid),
        .out_ready_i (st_ff == ST_IDLE && mode_on),
        .out_data_o  (cmd)
    );

    // data line input: three stages, accepted once stages two and three agree
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            lvl_ff   <= 1'b0;
        end else begin
            sync1_ff <= serial_data_line_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff) begin
                lvl_ff <= sync2_ff;
            end
        end
    end

    assign sd_now   = (sync2_ff == sync3_ff) ? sync2_ff : lvl_ff;
    assign rdy_rise = (sync2_ff == sync3_ff) && sync2_ff && !lvl_ff;

    // shift sequencer
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_ff        <= ST_IDLE;
            half_ff      <= 4'h0;
            bits_left_ff <= 4'h0;
            xfer_cnt_ff  <= 4'h0;
            shreg_ff     <= DATA_RESET;
            rd_ff        <= 1'b0;
            hiz_ff       <= 1'b0;
            wfr_ff       <= 1'b0;
            sck_ff       <= 1'b0;
            sd_out_ff    <= 1'b0;
            sd_oe_n_ff   <= 1'b1;
        end else if (!mode_on) begin
            // pins are handed back while another interface owns them
            st_ff      <= ST_IDLE;
            half_ff    <= 4'h0;
            sck_ff     <= 1'b0;
            sd_oe_n_ff <= 1'b1;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (cmd_pop) begin
                        rd_ff        <= cmd_ctl[CTL_RD_BIT];
                        hiz_ff       <= cmd_ctl[CTL_HIZ_BIT];
                        wfr_ff       <= cmd_ctl[CTL_WFR_BIT] && cmd_ctl[CTL_HIZ_BIT];
                        xfer_cnt_ff  <= cmd_cnt;
                        bits_left_ff <= cmd_cnt;
                        half_ff      <= 4'h0;
                        shreg_ff     <= cmd_ctl[CTL_RD_BIT] ? 8'h00 : cmd[7:0];
                        sd_out_ff    <= cmd[7];
                        if (cmd_cnt == 4'h0) begin
                            sd_oe_n_ff <= cmd_ctl[CTL_HIZ_BIT];
                            st_ff      <= (cmd_ctl[CTL_WFR_BIT] && cmd_ctl[CTL_HIZ_BIT]) ? ST_WAIT : ST_IDLE;
                        end else begin
                            sd_oe_n_ff <= cmd_ctl[CTL_RD_BIT];
                            st_ff      <= ST_LOW;
                        end
                    end
                end
                ST_LOW: begin
                    half_ff <= half_ff + 4'h1;
                    if (half_done) begin
                        half_ff      <= 4'h0;
                        sck_ff       <= 1'b1;
                        st_ff        <= ST_HIGH;
                        bits_left_ff <= bits_left_ff - 4'h1;
                        if (rd_ff) begin
                            shreg_ff <= {shreg_ff[6:0], sd_now};
                        end
                        if (bits_left_ff == 4'h1 && hiz_ff) begin
                            sd_oe_n_ff <= 1'b1;
                        end
                    end
                end
                ST_HIGH: begin
                    half_ff <= half_ff + 4'h1;
                    if (half_done) begin
                        half_ff <= 4'h0;
                        sck_ff  <= 1'b0;
                        if (bits_left_ff == 4'h0) begin
                            st_ff <= wfr_ff ? ST_WAIT : ST_IDLE;
                            if (!hiz_ff) begin
                                sd_oe_n_ff <= 1'b0;
                            end
                        end else begin
                            st_ff <= ST_LOW;
                            if (!rd_ff) begin
                                shreg_ff  <= {shreg_ff[6:0], 1'b0};
                                sd_out_ff <= shreg_ff[6];
                            end
                        end
                    end
                end
                ST_WAIT: begin
                    // eeprom pulls data high once its internal write finishes
                    if (rdy_rise) begin
                        st_ff <= ST_IDLE;
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // register file: control shadow and data register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_ff <= CTRL_RESET;
            data_ff <= DATA_RESET;
        end else begin
            if (sfr_ctrl_wr_i && mode_on && cmd_ready_o) begin
                ctrl_ff <= sfr_wdata_i;
            end
            // a finishing read wins over a same-cycle processor write
            if (xfer_end && rd_ff) begin
                data_ff <= shreg_ff;
            end else if (sfr_data_wr_i) begin
                data_ff <= sfr_wdata_i;
            end
        end
    end

    // chip select belongs to firmware alone
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cs_ff <= CS_RESET;
        end else if (cs_wr_i) begin
            cs_ff <= cs_val_i;
        end
    end

    // completion event on busy falling
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy_prev_ff <= 1'b0;
            irq_ff       <= 1'b0;
        end else begin
            busy_prev_ff <= busy;
            irq_ff       <= busy_prev_ff && !busy;
        end
    end

    // rising clock edges counted per transfer, read only by checks
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || cmd_pop) begin
            edge_cnt_ff <= 4'h0;
        end else if (st_ff == ST_LOW && half_done && mode_on) begin
            edge_cnt_ff <= edge_cnt_ff + 4'h1;
        end
    end

    assign ctrl_rdata_o              = {ctrl_ff[7], busy_prev_ff, ctrl_ff[5:0]};
    assign data_rdata_o              = data_ff;
    assign general_io_pin_o          = cs_ff;
    assign sck_o                     = sck_ff;
    assign serial_data_signal_o      = sd_out_ff;
    assign serial_data_signal_oe_n_o = sd_oe_n_ff;
    assign eeprom_done_irq_o         = irq_ff;

    property p_sck_half;
        @(posedge clk_sys_i) disable iff (rst_i || !mode_on)
        $rose(sck_ff) |-> ##10 $fell(sck_ff);
    endproperty
    a_sck_half: assert property (p_sck_half) else $error("serial clock high time wrong");
    property p_mode_gate;
        @(posedge clk_sys_i) disable iff (rst_i)
        !mode_on ##1 !mode_on |-> !sck_ff && sd_oe_n_ff && st_ff == ST_IDLE;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("shifter active outside three-wire mode");

    property p_write_starts;
        @(posedge clk_sys_i) disable iff (rst_i)
        sfr_ctrl_wr_i && mode_on && cmd_ready_o |-> ##2 (ctrl_rdata_o[CTL_BUSY_BIT] || !mode_on);
    endproperty
    a_write_starts: assert property (p_write_starts) else $error("control write did not raise busy");
    property p_wait_holds;
        @(posedge clk_sys_i) disable iff (rst_i || !mode_on)
        st_ff == ST_WAIT && !rdy_rise |=> st_ff == ST_WAIT;
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("ready wait left without rising edge");

    property p_wait_needs_float;
        @(posedge clk_sys_i) disable iff (rst_i)
        st_ff == ST_WAIT |-> hiz_ff;
    endproperty
    a_wait_needs_float: assert property (p_wait_needs_float) else $error("ready wait with float clear");
    property p_irq_on_fall;
        @(posedge clk_sys_i) disable iff (rst_i)
        busy_prev_ff && !busy |=> eeprom_done_irq_o ##1 !eeprom_done_irq_o;
    endproperty
    a_irq_on_fall: assert property (p_irq_on_fall) else $error("done event missing on busy fall");

    property p_float_last;
        @(posedge clk_sys_i) disable iff (rst_i || !mode_on)
        $rose(sck_ff) && bits_left_ff == 4'h0 && hiz_ff |-> sd_oe_n_ff;
    endproperty
    a_float_last: assert property (p_float_last) else $error("data driver not released after last clock");
    property p_read_floats;
        @(posedge clk_sys_i) disable iff (rst_i || !mode_on)
        rd_ff && (st_ff == ST_LOW || sck_ff) |-> sd_oe_n_ff;
    endproperty
    a_read_floats: assert property (p_read_floats) else $error("data line driven during read");

    property p_clock_count;
        @(posedge clk_sys_i) disable iff (rst_i)
        xfer_end |=> edge_cnt_ff == xfer_cnt_ff && edge_cnt_ff <= MAX_BITS;
    endproperty
    a_clock_count: assert property (p_clock_count) else $error("clock pulse count differs from count");
    property p_read_lands;
        @(posedge clk_sys_i) disable iff (rst_i)
        xfer_end && rd_ff |=> data_ff == $past(shreg_ff);
    endproperty
    a_read_lands: assert property (p_read_lands) else $error("read data not stored");

    property p_write_msb;
        @(posedge clk_sys_i) disable iff (rst_i || !mode_on)
        st_ff == ST_LOW && !rd_ff |-> sd_out_ff == shreg_ff[7] && !sd_oe_n_ff;
    endproperty
    a_write_msb: assert property (p_write_msb) else $error("write bit not taken from msb");
    property p_zero_count;
        @(posedge clk_sys_i) disable iff (rst_i || !mode_on)
        cmd_pop && cmd_cnt == 4'h0 |=> !sck_ff && sd_oe_n_ff == $past(cmd_ctl[CTL_HIZ_BIT]);
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("zero count transfer misbehaved");

    property p_cs_firmware;
        @(posedge clk_sys_i) disable iff (rst_i)
        !cs_wr_i |=> $stable(general_io_pin_o);
    endproperty
    a_cs_firmware: assert property (p_cs_firmware) else $error("chip select moved without firmware write");
endmodule

/* eeprom_model.sv */
// behavioural model of the external three-wire serial eeprom
module eeprom_model (
    // clock
    input  wire logic        clk_sys_i,
    // pins as the eeprom sees them
    input  wire logic        cs_i,
    input  wire logic        sck_i,
    input  wire logic        dut_sd_i,
    input  wire logic        dut_oe_n_i,
    output logic             line_o,
    // bench controls and probes
    input  wire logic        rd_mode_i,
    input  wire logic [7:0]  rd_byte_i,
    input  wire logic        busy_go_i,
    input  wire logic [15:0] busy_len_i,
    input  wire logic        clr_i,
    output logic      [7:0]  rx_o,
    output logic      [7:0]  rises_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic        sck_q   = 1'b0;
    logic        last    = 1'b0;
    logic        line_q  = 1'b0;
    logic [2:0]  bit_idx = 3'h7;
    logic [15:0] busy_n  = 16'h0000;
    logic        m_oe;
    logic        m_d;

    // the eeprom only talks once the shifter has let go of the line
    assign m_oe   = dut_oe_n_i && ((cs_i && rd_mode_i) || busy_n != 16'h0000);
    assign m_d    = (busy_n != 16'h0000) ? 1'b0 : rd_byte_i[bit_idx];
    // no pull on this line: released, it shows the opposite of its last level
    assign line_o = !dut_oe_n_i ? dut_sd_i : (m_oe ? m_d : ~last);

    always @(posedge clk_sys_i) begin
        sck_q  <= sck_i;
        line_q <= line_o;
        if (!dut_oe_n_i || m_oe) begin
            last <= line_o;
        end
        // line_q holds the level from just before the rise, as a real part latches it
        if (clr_i) begin
            rises_o <= 8'h00;
            rx_o    <= 8'h00;
        end else if (sck_i && !sck_q) begin
            rises_o <= rises_o + 8'h01;
            rx_o    <= {rx_o[6:0], line_q};
        end
        if (!cs_i || !rd_mode_i) begin
            bit_idx <= 3'h7;
        end else if (!sck_i && sck_q) begin
            bit_idx <= bit_idx - 3'h1;
        end
        if (busy_go_i) begin
            busy_n <= busy_len_i;
        end else if (busy_n != 16'h0000) begin
            busy_n <= busy_n - 16'h0001;
        end
    end
endmodule

/* three_wire_eeprom_shifter_test.sv */
// self-checking bench for the three-wire eeprom shifter
module three_wire_eeprom_shifter_test
    import eeprom_shifter_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        sfr_ctrl_wr_i = 1'b0;
    logic        sfr_data_wr_i = 1'b0;
    logic [7:0]  sfr_wdata_i = 8'h00;
    logic [1:0]  eeprom_port_select_i = 2'h3;
    logic        cs_wr_i = 1'b0;
    logic        cs_val_i = 1'b0;
    logic        rd_mode = 1'b0;
    logic [7:0]  rd_byte = 8'h00;
    logic        busy_go = 1'b0;
    logic [15:0] busy_len = 16'h0190;
    logic        clr = 1'b0;
    logic [7:0]  ctrl_rdata_o;
    logic [7:0]  data_rdata_o;
    logic        cmd_ready_o;
    logic        general_io_pin_o;
    logic        sck_o;
    logic        serial_data_signal_o;
    logic        serial_data_signal_oe_n_o;
    logic        line;
    logic        eeprom_done_irq_o;
    logic [7:0]  rx;
    logic [7:0]  rises;
    logic        sck_q = 1'b0;
    int          cyc, last_rise, period, irq_n, waited, checks, fail_count;

    three_wire_eeprom_shifter uut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sfr_ctrl_wr_i(sfr_ctrl_wr_i),
        .sfr_data_wr_i(sfr_data_wr_i), .sfr_wdata_i(sfr_wdata_i), .ctrl_rdata_o(ctrl_rdata_o),
        .data_rdata_o(data_rdata_o), .cmd_ready_o(cmd_ready_o), .eeprom_port_select_i(eeprom_port_select_i),
        .cs_wr_i(cs_wr_i), .cs_val_i(cs_val_i), .general_io_pin_o(general_io_pin_o), .sck_o(sck_o),
        .serial_data_signal_o(serial_data_signal_o), .serial_data_signal_oe_n_o(serial_data_signal_oe_n_o),
        .serial_data_line_i(line), .eeprom_done_irq_o(eeprom_done_irq_o));

    eeprom_model partner (
        .clk_sys_i(clk_sys_i), .cs_i(general_io_pin_o), .sck_i(sck_o), .dut_sd_i(serial_data_signal_o),
        .dut_oe_n_i(serial_data_signal_oe_n_o), .line_o(line), .rd_mode_i(rd_mode), .rd_byte_i(rd_byte),
        .busy_go_i(busy_go), .busy_len_i(busy_len), .clr_i(clr), .rx_o(rx), .rises_o(rises));

    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        sck_q <= sck_o;
        if (sck_o && !sck_q) begin
            period <= cyc - last_rise;
            last_rise <= cyc;
        end
        if (eeprom_done_irq_o === 1'b1) begin
            irq_n <= irq_n + 1;
        end
    end

    task automatic tick(input int n = 1);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_data(input logic [7:0] b);
        sfr_data_wr_i = 1'b1;
        sfr_wdata_i = b;
        tick();
        sfr_data_wr_i = 1'b0;
    endtask

    task automatic wr_ctrl(input logic [7:0] b);
        sfr_ctrl_wr_i = 1'b1;
        sfr_wdata_i = b;
        tick();
        sfr_ctrl_wr_i = 1'b0;
    endtask

    task automatic set_cs(input logic v);
        cs_wr_i = 1'b1;
        cs_val_i = v;
        tick();
        cs_wr_i = 1'b0;
    endtask

    // busy shows two cycles late, so the poll starts after that
    task automatic wait_idle(input int limit);
        waited = 0;
        tick(3);
        while (ctrl_rdata_o[CTL_BUSY_BIT] !== 1'b0 && waited < limit) begin
            tick();
            waited++;
        end
        check("busy drops in time", 8'(waited < limit), 8'h01);
        tick(2);
    endtask

    task automatic xfer(input logic [7:0] d, input logic [7:0] c, input logic go);
        clr = 1'b1;
        wr_data(d);
        clr = 1'b0;
        busy_go = go;
        wr_ctrl(c);
        busy_go = 1'b0;
        wait_idle(2000);
    endtask

    task automatic t_reset();
        check("ctrl reset", ctrl_rdata_o, CTRL_RESET);
        check("data reset", data_rdata_o, DATA_RESET);
        check("cs reset", 8'(general_io_pin_o), 8'(CS_RESET));
        check("line floated", 8'(serial_data_signal_oe_n_o), 8'h01);
    endtask

    task automatic t_write();
        int irq0;
        set_cs(1'b1);
        check("cs pin high", 8'(general_io_pin_o), 8'h01);
        irq0 = irq_n;
        xfer(8'hA5, 8'h08, 1'b0);
        check("write bits", rx, 8'hA5);
        check("write clocks", rises, 8'(MAX_BITS));
        check("sck period", 8'(period), 8'(2 * SCK_HALF_CYC));
        check("line driven", 8'(serial_data_signal_oe_n_o), 8'h00);
        check("done pulses", 8'(irq_n - irq0), 8'h01);
        check("data kept", data_rdata_o, 8'hA5);
        xfer(8'h81, 8'h0F, 1'b0);
        check("clamped clocks", rises, 8'h08);
        check("clamped bits", rx, 8'h81);
        xfer(8'hD0, 8'h03, 1'b0);
        check("partial bits", rx, 8'h06);
        check("partial clocks", rises, 8'h03);
        xfer(8'h3C, 8'h28, 1'b0);
        check("float bits", rx, 8'h3C);
        check("float after", 8'(serial_data_signal_oe_n_o), 8'h01);
        xfer(8'h00, 8'h20, 1'b0);
        check("zero clocks", rises, 8'h00);
        check("zero floats", 8'(serial_data_signal_oe_n_o), 8'h01);
    endtask

    task automatic t_read();
        rd_mode = 1'b1;
        rd_byte = 8'hB3;
        xfer(8'hFF, 8'h35, 1'b0);
        check("read data", data_rdata_o, 8'h16);
        check("read clocks", rises, 8'h05);
        check("read floats", 8'(serial_data_signal_oe_n_o), 8'h01);
        set_cs(1'b0);
        rd_mode = 1'b0;
        check("cs pin low", 8'(general_io_pin_o), 8'h00);
        xfer(8'h00, 8'h00, 1'b0);
        check("retake line", 8'(serial_data_signal_oe_n_o), 8'h00);
        check("retake clocks", rises, 8'h00);
    endtask

    task automatic t_wfr();
        set_cs(1'b1);
        clr = 1'b1;
        wr_data(8'h55);
        clr = 1'b0;
        busy_go = 1'b1;
        wr_ctrl(8'hA8);
        busy_go = 1'b0;
        tick(300);
        check("busy held", 8'(ctrl_rdata_o[CTL_BUSY_BIT]), 8'h01);
        check("ctrl readback", ctrl_rdata_o, 8'hE8);
        wait_idle(400);
        check("ready waited", 8'(waited > 50), 8'h01);
        xfer(8'h55, 8'h88, 1'b1);
        check("wait ignored", 8'(waited < 250), 8'h01);
    endtask

    task automatic t_port();
        eeprom_port_select_i = 2'h2;
        clr = 1'b1;
        wr_data(8'h0F);
        clr = 1'b0;
        wr_ctrl(8'h08);
        tick(50);
        check("off mode clocks", rises, 8'h00);
        check("off mode busy", 8'(ctrl_rdata_o[CTL_BUSY_BIT]), 8'h00);
        eeprom_port_select_i = 2'h3;
    endtask

    // one long transfer keeps the shifter busy while the queue fills behind it
    task automatic t_fifo();
        clr = 1'b1;
        wr_data(8'hF0);
        clr = 1'b0;
        sfr_ctrl_wr_i = 1'b1;
        sfr_wdata_i = 8'h08;
        tick();
        sfr_wdata_i = 8'h01;
        tick(8);
        check("queue full", 8'(cmd_ready_o), 8'h00);
        tick();
        sfr_ctrl_wr_i = 1'b0;
        wait_idle(2000);
        check("queued clocks", rises, 8'h10);
        check("queue empty", 8'(cmd_ready_o), 8'h01);
    endtask

    task automatic results();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        tick(8);
        rst_i = 1'b0;
        tick();
        t_reset();
        t_write();
        t_read();
        t_wfr();
        t_port();
        t_fifo();
        results();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail_count++;
        $display("BAD watchdog expired");
        results();
    end
endmodule
